// [bench/msq_conv_model.sv]
// converter model: answers each start with one result after lat+1 cycles
// assumes conv.start is a one-cycle pulse synchronous to clk_sys
module msq_conv_model
	import msq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire msq_conv_t conv,
	input wire logic [15:0] key,
	input wire logic [7:0] lat,
	output logic conv_done,
	output logic [15:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q;
	logic [7:0] cnt_q;
	logic [15:0] val_q;
	// data toggles when no result stands, so a stale word never looks valid
	always_ff @(posedge clk_sys) begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data;
		if (!rst_n) begin
			busy_q <= 1'b0;
			conv_data <= 16'h0000;
		end else if (conv.start) begin
			busy_q <= 1'b1;
			cnt_q <= lat;
			val_q <= conv.cfg ^ key;
		end else if (busy_q && cnt_q == 8'h00) begin
			busy_q <= 1'b0;
			conv_done <= 1'b1;
			conv_data <= val_q;
		end else begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

// [bench/mux_adc_channel_sequencer_tb.sv]
// bench for the channel sequencer: runs, aborts, modes and result commits
// assumes the converter model of msq_conv_model.sv on the far side
`include "msq_map.svh"
module mux_adc_channel_sequencer_tb
	import msq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	msq_bus_req_t bus = '0;
	logic [15:0] bus_rdata;
	logic current_conv_start = 1'b0;
	logic conv_done;
	logic [15:0] conv_data;
	msq_conv_t conv;
	logic run_active_flag;
	logic [15:0] key = 16'h5a5a;
	logic [7:0] lat = 8'h01;
	logic rd_seen = 1'b0;
	logic [15:0] exp_rd[$];
	logic [15:0] exp_cfg[$];
	logic [15:0] cfg[16];
	int err_total = 0;
	int cmp_count = 0;
	int n_st = 0;
	int base;

	always #12.5 clk_sys = ~clk_sys;

	msq_seq msq_seq_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
		.current_conv_start(current_conv_start), .conv_done(conv_done),
		.conv_data(conv_data), .conv(conv), .run_active_flag(run_active_flag));
	msq_conv_model msq_conv_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .conv(conv),
		.key(key), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_rd.push_back(e);
		@(posedge clk_sys);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
	endtask
	task automatic wait_act(input logic lvl);
		int n = 0;
		while (run_active_flag !== lvl && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		chk({15'h0, run_active_flag}, {15'h0, lvl}, "active level");
	endtask
	task automatic wait_st(input int k);
		int n = 0;
		while (n_st < k && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		chk(16'(n_st), 16'(k), "start count");
	endtask
	task automatic pulse();
		@(posedge clk_sys);
		current_conv_start <= 1'b1;
		@(posedge clk_sys);
		current_conv_start <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys) rd_seen <= bus.rd;
	always @(negedge clk_sys) begin
		if (rd_seen)
			chk(bus_rdata, exp_rd.pop_front(), "read data");
		if (conv.start === 1'b1) begin
			n_st++;
			if (exp_cfg.size() > 0)
				chk(conv.cfg, exp_cfg.pop_front(), "step config");
		end
	end

	initial begin
		void'($urandom(32'h80f79c39));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`MSQ_REG_RES_BASE, `MSQ_RST_WORD);
		rd(`MSQ_REG_STATUS, 16'h0000);
		wr(`MSQ_REG_STEP_EN, 16'h8005);
		wr(`MSQ_REG_SEQCFG, 16'h0011);
		for (int i = 0; i < 16; i++) begin
			cfg[i] = 16'($urandom) & 16'h0fff;
			wr(8'(`MSQ_REG_CFG_BASE + i), cfg[i]);
		end
		wr(`MSQ_REG_CTRL, 16'h0001);
		repeat (4) @(negedge clk_sys);
		chk({15'h0, run_active_flag}, 16'h0000, "start while off");
		$display("test 1 done");
		wr(`MSQ_REG_DEVCFG, 16'h0001);
		exp_cfg = '{cfg[0], cfg[2], cfg[15]};
		wr(`MSQ_REG_CTRL, 16'h0001);
		base = 0;
		while (conv.start !== 1'b1 && base < 400) begin
			@(negedge clk_sys);
			base++;
		end
		chk(16'(base), 16'h0051, "settle cycles");
		wait_st(2);
		rd(`MSQ_REG_RES_BASE, 16'h0000);
		wait_act(1'b0);
		for (int i = 0; i < 16; i++)
			rd(8'(`MSQ_REG_RES_BASE + i), ((16'h8005 >> i) & 16'h0001) ? cfg[i] ^ key : 16'h0000);
		chk(16'(n_st), 16'h0003, "conversions");
		repeat (100) @(negedge clk_sys);
		chk({15'h0, run_active_flag}, 16'h0000, "one run");
		$display("test 2 done");
		// slow converter, restart mid-run with start and stop together
		wr(`MSQ_REG_CTRL, 16'h0001);
		lat <= 8'h1e;
		key <= 16'hc3c3;
		base = n_st;
		wait_st(base + 2);
		rd(`MSQ_REG_RES_BASE, cfg[0] ^ 16'h5a5a);
		wr(`MSQ_REG_CTRL, 16'h0003);
		exp_cfg = '{cfg[0], cfg[2], cfg[15]};
		wait_st(base + 5);
		wait_act(1'b0);
		rd(8'(`MSQ_REG_RES_BASE + 2), cfg[2] ^ 16'hc3c3);
		$display("test 3 done");
		wr(`MSQ_REG_CTRL, 16'h0001);
		wait_st(n_st + 1);
		wr(`MSQ_REG_DEVCFG, 16'h0000);
		repeat (2) @(negedge clk_sys);
		chk({15'h0, run_active_flag}, 16'h0000, "abort on disable");
		rd(8'(`MSQ_REG_RES_BASE + 2), 16'h0000);
		$display("test 4 done");
		wr(`MSQ_REG_SEQCFG, 16'h0000);
		wr(`MSQ_REG_DEVCFG, 16'h0001);
		wr(`MSQ_REG_CTRL, 16'h0003);
		wait_act(1'b1);
		wait_act(1'b0);
		wait_act(1'b1);
		rd(8'(`MSQ_REG_RES_BASE + 15), cfg[15] ^ 16'hc3c3);
		wr(`MSQ_REG_CTRL, 16'h0002);
		rd(`MSQ_REG_CTRL, 16'h0002);
		wait_act(1'b0);
		repeat (5) @(negedge clk_sys);
		rd(`MSQ_REG_STATUS, 16'h0000);
		rd(`MSQ_REG_CTRL, 16'h0000);
		$display("test 5 done");
		wr(`MSQ_REG_DEVCFG, 16'h0000);
		wr(`MSQ_REG_SEQCFG, 16'h0002);
		wr(`MSQ_REG_DEVCFG, 16'h0001);
		wr(`MSQ_REG_CTRL, 16'h0001);
		repeat (3) @(negedge clk_sys);
		wait_act(1'b0);
		base = n_st;
		pulse();
		wait_act(1'b1);
		wait_st(base + 1);
		pulse();
		wait_act(1'b0);
		chk(16'(n_st - base), 16'h0003, "sync no restart");
		repeat (5) @(negedge clk_sys);
		chk({15'h0, run_active_flag}, 16'h0000, "sync idle");
		$display("test 6 done");
		print_verdict();
	end

	initial begin
		#1000000;
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule

// [rtl/msq_map.svh]
// register offsets, field positions and timing counts of the channel sequencer
// assumes a 40 MHz system clock and an 8-bit register index on the bus
`ifndef MSQ_MAP_SVH
`define MSQ_MAP_SVH

`define MSQ_NUM_STEPS 16
`define MSQ_REG_CTRL 8'h01
`define MSQ_REG_STATUS 8'h02
`define MSQ_REG_DEVCFG 8'h03
`define MSQ_REG_RES_BASE 8'h10
`define MSQ_REG_STEP_EN 8'h8c
`define MSQ_REG_SEQCFG 8'h8d
`define MSQ_REG_CFG_BASE 8'h90

`define MSQ_CTRL_START 0
`define MSQ_CTRL_STOP 1
`define MSQ_STAT_ACTIVE 0
`define MSQ_STAT_STOP 1
`define MSQ_DEV_ENABLE 0
`define MSQ_DEV_STANDBY 1
`define MSQ_DEV_PDOWN 2
`define MSQ_SEQCFG_MODE_LSB 0
`define MSQ_SEQCFG_DLY_LSB 4

`define MSQ_RST_WORD 16'h0000
`define MSQ_CLK_NS 25
`define MSQ_SETTLE_UNIT_NS 1000
`define MSQ_SETTLE_UNIT_CYC ((`MSQ_SETTLE_UNIT_NS + `MSQ_CLK_NS - 1) / `MSQ_CLK_NS)

`endif

// [rtl/msq_pkg.sv]
// types shared by the channel sequencer and its bench
// assumes nothing beyond a SystemVerilog compiler
package msq_pkg;

	typedef enum logic [1:0] {MSQ_IDLE, MSQ_SETTLE, MSQ_CONV} msq_fsm_t;

	typedef enum logic [1:0] {MSQ_MODE_CONT, MSQ_MODE_SINGLE, MSQ_MODE_SYNC} msq_mode_t;

	typedef struct packed {
		logic [3:0] spare;
		logic [3:0] gain;
		logic [3:0] pos_sel;
		logic [3:0] neg_sel;
	} msq_step_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} msq_bus_req_t;

	typedef struct packed {
		logic start;
		msq_step_cfg_t cfg;
	} msq_conv_t;

	typedef struct packed {
		msq_fsm_t st;
		logic [3:0] step;
		logic [8:0] cnt;
		logic active;
		logic stop_pend;
		logic armed;
		logic rerun;
		logic conv_en;
		logic standby;
		logic pdown;
		logic [15:0] step_en;
		logic [1:0] mode;
		logic [2:0] dsel;
		msq_step_cfg_t [15:0] cfg;
		logic [15:0][15:0] shadow;
		logic [15:0][15:0] res;
		logic [15:0] rdata;
		msq_conv_t conv;
	} msq_state_t;

endpackage

// [rtl/msq_seq.sv]
// channel sequencer for the multiplexed 16-bit converter, with its register file
// assumes bus strobes and converter handshakes synchronous to clk_sys
`include "msq_map.svh"

// Functional notes
// - sixteen steps, each enabled by its own step_enable bit.
// - every run starts at step 0 and walks enabled steps upward.
// - each step applies its gain and input selects, then one conversion.
// - a global 3-bit select sets the settle delay before each conversion.
// - run_active_flag is high exactly while a run is in progress.
// - run_start_bit written while converter disabled is ignored.
// - each step has a 16-bit readable result; disabled steps read 0000.
// - results update together only at run end; never mixed between runs.
// - 2-bit mode selects continuous, single-shot or synchronized single-shot.
// - continuous mode repeats runs; start during a run restarts from step 0.
// - stop lets the current run finish; stop reads 1 until stopped.
// - disable, standby or power-down aborts a run at once.
// - start and stop in one write: start wins.
// - results stay after stop; cleared only by reset, disable, standby, power-down, or a start with no step enabled.
// - single-shot: one run per start, restart on start, stop ignored.
// - synchronized: current converter start triggers a run only when idle.
module msq_seq
	import msq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire msq_bus_req_t bus,
	output logic [15:0] bus_rdata,
	input wire logic current_conv_start,
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	output msq_conv_t conv,
	output logic run_active_flag
);

	msq_state_t q;
	msq_state_t d;
	logic run_ok;
	logic start_wr;
	logic stop_wr;
	logic begin_run;
	logic [4:0] nxt;
	logic [4:0] first;
	logic [8:0] settle_cyc;

	// lowest enabled step at or above 'from'; bit 4 flags a hit
	function automatic logic [4:0] msq_next(input logic [15:0] en, input logic [4:0] from);
		logic [4:0] r;
		r = '0;
		for (int i = 15; i >= 0; i--) begin
			if (en[i] && (5'(i) >= from)) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	assign run_ok = q.conv_en & ~q.standby & ~q.pdown;
	assign start_wr = bus.wr && (bus.addr == `MSQ_REG_CTRL) && bus.wdata[`MSQ_CTRL_START];
	assign stop_wr = bus.wr && (bus.addr == `MSQ_REG_CTRL) && bus.wdata[`MSQ_CTRL_STOP];
	assign settle_cyc = 9'(`MSQ_SETTLE_UNIT_CYC) * ({6'h00, q.dsel} + 9'h001);
	assign nxt = msq_next(q.step_en, {1'b0, q.step} + 5'h01);
	assign first = msq_next(q.step_en, 5'h00);

	always_comb begin
		d = q;
		d.conv.start = 1'b0;
		d.rdata = `MSQ_RST_WORD;
		begin_run = 1'b0;

		// register writes; host keeps config still while enabled, so no interlock
		if (bus.wr) begin
			unique case (bus.addr)
				`MSQ_REG_DEVCFG: begin
					d.conv_en = bus.wdata[`MSQ_DEV_ENABLE];
					d.standby = bus.wdata[`MSQ_DEV_STANDBY];
					d.pdown = bus.wdata[`MSQ_DEV_PDOWN];
				end
				`MSQ_REG_STEP_EN: d.step_en = bus.wdata;
				`MSQ_REG_SEQCFG: begin
					d.mode = bus.wdata[`MSQ_SEQCFG_MODE_LSB +: 2];
					d.dsel = bus.wdata[`MSQ_SEQCFG_DLY_LSB +: 3];
				end
				default: begin
					if (bus.addr[7:4] == `MSQ_REG_CFG_BASE >> 4) begin
						d.cfg[bus.addr[3:0]] = bus.wdata;
					end
				end
			endcase
		end

		if (!run_ok) begin
			// disable, standby and power-down drop the run, pending stop, trigger and results at once; config stays
			d.st = MSQ_IDLE;
			d.active = 1'b0;
			d.stop_pend = 1'b0;
			d.armed = 1'b0;
			d.rerun = 1'b0;
			d.shadow = '0;
			d.res = '0;
		end else begin
			if (start_wr) begin
				begin_run = 1'b1;
				d.stop_pend = 1'b0;
				d.rerun = 1'b0;
				if (q.mode == MSQ_MODE_SYNC) begin
					d.armed = 1'b1;
				end
			end else begin
				if (stop_wr && (q.mode == MSQ_MODE_CONT) && (q.active || q.rerun)) begin
					d.stop_pend = 1'b1;
				end
				if ((q.mode == MSQ_MODE_SYNC) && q.armed && current_conv_start && !q.active) begin
					begin_run = 1'b1;
				end
				if (q.rerun && !q.active) begin
					d.rerun = 1'b0;
					if (q.stop_pend || stop_wr || (q.mode != MSQ_MODE_CONT)) begin
						d.stop_pend = 1'b0;
					end else begin
						begin_run = 1'b1;
					end
				end
			end

			if (begin_run) begin
				// fresh shadow so a disabled step commits as zero
				d.shadow = '0;
				if (first[4]) begin
					d.st = MSQ_SETTLE;
					d.step = first[3:0];
					d.cnt = settle_cyc;
					d.conv.cfg = q.cfg[first[3:0]];
					d.active = 1'b1;
				end else begin
					d.st = MSQ_IDLE;
					d.res = '0;
					d.active = 1'b0;
					d.rerun = (q.mode == MSQ_MODE_CONT);
				end
			end else if (q.active) begin
				unique case (q.st)
					MSQ_SETTLE: begin
						if (q.cnt == 9'h001) begin
							d.st = MSQ_CONV;
							d.conv.start = 1'b1;
						end else begin
							d.cnt = q.cnt - 9'h001;
						end
					end
					MSQ_CONV: begin
						if (conv_done) begin
							d.shadow[q.step] = conv_data;
							if (nxt[4]) begin
								d.st = MSQ_SETTLE;
								d.step = nxt[3:0];
								d.cnt = settle_cyc;
								d.conv.cfg = q.cfg[nxt[3:0]];
							end else begin
								// whole set lands in one edge, so reads never mix runs
								d.res = d.shadow;
								d.active = 1'b0;
								d.st = MSQ_IDLE;
								d.rerun = (q.mode == MSQ_MODE_CONT);
							end
						end
					end
					MSQ_IDLE: d.active = 1'b0;
				endcase
			end
		end

		// read data answer lands the cycle after the strobe, old values during a run
		if (bus.rd) begin
			unique case (bus.addr)
				`MSQ_REG_CTRL: d.rdata[`MSQ_CTRL_STOP] = q.stop_pend;
				`MSQ_REG_STATUS: begin
					d.rdata[`MSQ_STAT_ACTIVE] = q.active;
					d.rdata[`MSQ_STAT_STOP] = q.stop_pend;
				end
				`MSQ_REG_DEVCFG: d.rdata[2:0] = {q.pdown, q.standby, q.conv_en};
				`MSQ_REG_STEP_EN: d.rdata = q.step_en;
				`MSQ_REG_SEQCFG: d.rdata = {9'h000, q.dsel, 2'h0, q.mode};
				default: begin
					if (bus.addr[7:4] == `MSQ_REG_RES_BASE >> 4) begin
						d.rdata = q.res[bus.addr[3:0]];
					end else if (bus.addr[7:4] == `MSQ_REG_CFG_BASE >> 4) begin
						d.rdata = q.cfg[bus.addr[3:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus_rdata = q.rdata;
	assign conv = q.conv;
	assign run_active_flag = q.active;

	property p_start_off;
		@(posedge clk_sys) disable iff (!rst_n)
		(start_wr && !run_ok) |=> !q.active;
	endproperty
	a_start_off: assert property (p_start_off) else $error("start taken while disabled");

	property p_abort;
		@(posedge clk_sys) disable iff (!rst_n)
		(q.active && !run_ok) |=> (!q.active && (q.st == MSQ_IDLE) && !run_active_flag);
	endproperty
	a_abort: assert property (p_abort) else $error("run not aborted on disable");

	property p_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		!run_ok |=> (q.res == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("results not cleared");

	property p_from_zero;
		@(posedge clk_sys) disable iff (!rst_n)
		(start_wr && run_ok && q.step_en[0]) |=> (q.active && (q.step == 4'h0) ##1 q.st == MSQ_SETTLE);
	endproperty
	a_from_zero: assert property (p_from_zero) else $error("run did not begin at step 0");

	property p_settle;
		@(posedge clk_sys) disable iff (!rst_n)
		q.conv.start |-> ($past(q.st) == MSQ_SETTLE && $past(q.cnt) == 9'h001);
	endproperty
	a_settle: assert property (p_settle) else $error("conversion before settle end");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(q.active && d.active) |=> $stable(q.res);
	endproperty
	a_hold: assert property (p_hold) else $error("results moved during a run");

	property p_commit;
		@(posedge clk_sys) disable iff (!rst_n)
		(run_ok && q.active && q.st == MSQ_CONV && conv_done && !begin_run && !nxt[4])
			|=> (!run_active_flag && q.res[$past(q.step)] == $past(conv_data));
	endproperty
	a_commit: assert property (p_commit) else $error("last step did not commit");

	property p_stop;
		@(posedge clk_sys) disable iff (!rst_n)
		(stop_wr && !start_wr && run_ok && q.active && q.mode == MSQ_MODE_CONT)
			|=> q.stop_pend;
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit not pending");

	property p_start_wins;
		@(posedge clk_sys) disable iff (!rst_n)
		(start_wr && stop_wr && run_ok) |=> !q.stop_pend;
	endproperty
	a_start_wins: assert property (p_start_wins) else $error("stop beat start");

	property p_sync_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		(run_ok && q.mode == MSQ_MODE_SYNC && q.st == MSQ_CONV && current_conv_start
			&& !start_wr && !conv_done) |=> (q.st == MSQ_CONV && $stable(q.step));
	endproperty
	a_sync_keep: assert property (p_sync_keep) else $error("sync trigger aborted a run");

endmodule
